// file: core/bsl_pkg.sv
package bsl_pkg;
  // core clock rate and internal reset phase
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned RST_PHASE_US  = 15;
  localparam int unsigned RST_PHASE_CYC = RST_PHASE_US * CLK_MHZ;
  localparam int unsigned RST_CNT_W     = 12;

  // serial flash clock is the core clock divided by this
  localparam int unsigned SPI_DIV      = 160;
  localparam int unsigned SPI_HALF_CYC = SPI_DIV / 2;
  localparam int unsigned SPI_CNT_W    = 7;
  localparam logic [7:0]  SPI_READ_CMD = 8'h03;
  localparam logic [23:0] SPI_ADDR0    = 24'h000000;
  localparam logic [5:0]  SPI_HDR_BITS = 6'h20;
  localparam logic [5:0]  SPI_BYTE_END = 6'h07;

  // image framing and check value
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_SKIP = 32'h0D15AB1E;
  localparam logic [1:0]  LAST_BYTE = 2'h3;

  // memory placement
  localparam int unsigned RAM_AW       = 14;
  localparam logic [13:0] RAM_BASE     = 14'h0000;
  localparam logic [15:0] OTP_BASE     = 16'h0000;
  localparam int unsigned SEC_BOOT_BIT = 5;

  // fifo shape
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 8;

  // pll field widths and strap defaults
  localparam logic [2:0]  PLL_PDIV_00 = 3'h1;
  localparam logic [11:0] PLL_F_00  = 12'h07A;
  localparam logic [2:0]  PLL_PDIV_XX = 3'h2;
  localparam logic [11:0] PLL_F_11  = 12'h077;
  localparam logic [11:0] PLL_F_10  = 12'h031;
  localparam logic [11:0] PLL_F_01  = 12'h017;
  localparam logic [5:0]  PLL_R_DEF = 6'h00;

  // boot strap codes
  localparam logic [1:0] BS_JTAG = 2'h0;
  localparam logic [1:0] BS_RSVD = 2'h1;
  localparam logic [2:0] BS_LINK = 3'h2;
  localparam logic [2:0] BS_SPI0 = 3'h3;
  localparam logic [2:0] BS_CHAN = 3'h6;
  localparam logic [2:0] BS_SPI1 = 3'h7;
  localparam logic [4:0] LINKS_B    = 5'h01;
  localparam logic [4:0] LINKS_BEFH = 5'h1F;

  typedef enum logic [2:0] {
    SRC_JTAG, SRC_RSVD, SRC_LINK, SRC_SPI, SRC_CHAN, SRC_OTP
  } bsl_src_e;

  // multiplier default picked by the two low straps
  function automatic logic [11:0] bsl_strap_mult(input logic [1:0] s);
    unique case (s)
      2'b00:   bsl_strap_mult = PLL_F_00;
      2'b11:   bsl_strap_mult = PLL_F_11;
      2'b10:   bsl_strap_mult = PLL_F_10;
      default: bsl_strap_mult = PLL_F_01;
    endcase
  endfunction : bsl_strap_mult

  // output divider default picked by the two low straps
  function automatic logic [2:0] bsl_strap_pdiv(input logic [1:0] s);
    bsl_strap_pdiv = (s == 2'b00) ? PLL_PDIV_00 : PLL_PDIV_XX;
  endfunction : bsl_strap_pdiv
endpackage : bsl_pkg

// file: core/bsl_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module bsl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];   // storage words
  logic [AW-1:0]    wr_ptr_ff;     // next slot to fill
  logic [AW-1:0]    rd_ptr_ff;     // next slot to drain
  logic [AW:0]      cnt_ff;        // words held
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
  assign out_valid = (cnt_ff != '0);
  assign out_data  = mem[rd_ptr_ff];
  assign level     = cnt_ff;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage write, no reset needed on data
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data;
    end
  end

  // pointers wrap naturally, depth is a power of two
  always_ff @(posedge clk) begin
    if (reset) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      cnt_ff    <= '0;
    end else begin
      if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (pop)  rd_ptr_ff <= rd_ptr_ff + 1'b1;
      cnt_ff <= cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : bsl_fifo
`default_nettype wire

// file: core/bsl_crc32.sv
`timescale 1ns/1ps
`default_nettype none
module bsl_crc32
  import bsl_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // control
  input  wire logic        clear,
  input  wire logic        en,
  input  wire logic [7:0]  data,
  // running remainder, not yet inverted
  output logic [31:0]      crc
);
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;

  // reflected form: one bit per step, low bit first
  always_comb begin
    nxt_crc = crc_ff;
    for (int i = 0; i < 8; i++) begin
      if (nxt_crc[0] ^ data[i]) nxt_crc = (nxt_crc >> 1) ^ CRC_POLY;
      else                      nxt_crc = nxt_crc >> 1;
    end
  end

  // preset on clear, update per byte
  always_ff @(posedge clk) begin
    if (reset || clear) crc_ff <= CRC_INIT;
    else if (en)        crc_ff <= nxt_crc;
  end

  assign crc = crc_ff;
endmodule : bsl_crc32
`default_nettype wire

// file: core/bsl_loader.sv
// What this block does
// RL1 - pins undriven while chip reset held
// RL2 - internal reset phase, then pulls, then boot
// RL3 - low straps pick default pll settings
// RL4 - core ratio from multiplier and dividers
// RL5 - software keeps pll fields in range
// RL6 - software may rewrite pll settings
// RL7 - board holds straps steady through reset
// RL8 - straps x00 wait jtag, x01 reserved
// RL9 - 010 link b, 011 serial flash
// RL10 - 110 links b,e-h channel, 111 flash
// RL11 - secure bit forces otp boot
// RL12 - image: count, words, crc or skip
// RL13 - count and crc least byte first
// RL14 - load from ram base, run there
// RL15 - crc covers count and program bytes
// RL16 - reflected crc, preset ones, inverted result
// RL17 - flash read cmd, address zero, clk/160
// RL18 - flash bytes arrive low bit first
// RL19 - secure boot reads otp from zero
// RL20 - crc mismatch flags error, no run
// RL21 - boot source sampled once, held
`timescale 1ns/1ps
`default_nettype none
module bsl_loader
  import bsl_pkg::*;
(
  // clock and reset
  input  wire logic              clk,
  input  wire logic              reset,
  // straps and security
  input  wire logic              pll_strap_lo,
  input  wire logic              pll_strap_hi,
  input  wire logic [2:0]        boot_strap,
  input  wire logic [31:0]       security_reg,
  // software pll write
  input  wire logic              pll_cfg_we,
  input  wire logic [2:0]        pll_cfg_pdiv,
  input  wire logic [11:0]       pll_cfg_mult,
  input  wire logic [5:0]        pll_cfg_indiv,
  // pll settings out
  output logic [2:0]             output_divide_value_ff,
  output logic [11:0]            pll_mult_ff,
  output logic [5:0]             pll_indiv_ff,
  output logic [12:0]            core_ratio_num_ff,
  output logic [10:0]            core_ratio_den_ff,
  // pad control
  output logic                   gpio_pull_en_ff,
  output logic                   spi_oe_ff,
  output logic [4:0]             link_en_ff,
  // serial flash
  output logic                   spi_sclk_ff,
  output logic                   spi_cs_n_ff,
  output logic                   spi_mosi_ff,
  input  wire logic              spi_miso,
  // link or channel byte stream
  input  wire logic              link_valid,
  input  wire logic [7:0]        link_byte,
  output logic                   link_ready_ff,
  // otp read port
  output logic                   otp_rd_ff,
  output logic [15:0]            otp_addr_ff,
  input  wire logic              otp_rvalid,
  input  wire logic [31:0]       otp_rdata,
  // ram write port
  output logic                   ram_we_ff,
  output logic [RAM_AW-1:0]      ram_addr_ff,
  output logic [31:0]            ram_wdata_ff,
  // boot status
  output logic                   wait_jtag_ff,
  output logic                   tile1_via_tile0_ff,
  output logic                   exec_start_ff,
  output logic [RAM_AW-1:0]      exec_addr_ff,
  output logic                   boot_error_ff
);
  typedef enum logic [2:0] {
    ST_RST_PHASE, ST_DECODE, ST_WAIT_JTAG, ST_COUNT, ST_PROG, ST_CRC, ST_RUN, ST_FAIL
  } bsl_state_e;

  bsl_state_e            state_ff;        // boot sequence state
  bsl_src_e              src_ff;          // decoded boot source
  logic [RST_CNT_W-1:0]  phase_cnt_ff;    // internal reset timer
  logic                  loading;         // any image phase
  logic                  f_in_valid;      // fifo fill side
  logic [7:0]            f_in_data;
  logic                  f_in_ready;
  logic                  f_out_valid;     // fifo drain side
  logic [7:0]            f_out_data;
  logic [3:0]            f_level;
  logic                  pop;
  logic [1:0]            byte_idx_ff;     // byte within word
  logic [31:0]           word_ff;         // assembled word
  logic [31:0]           word_now;        // word incl. current byte
  logic                  word_done;
  logic [31:0]           words_left_ff;   // program words to go
  logic [31:0]           crc_run;
  logic                  crc_ok;
  // flash engine
  logic [SPI_CNT_W-1:0]  spi_cnt_ff;
  logic                  spi_tick;
  logic [5:0]            spi_bits_ff;
  logic [31:0]           spi_sh_ff;
  logic                  spi_hdr_ff;      // sending command/address
  logic [7:0]            spi_rx_ff;
  logic                  spi_push;
  // otp engine
  logic                  otp_pend_ff;
  logic                  otp_have_ff;
  logic [31:0]           otp_word_ff;
  logic [1:0]            otp_idx_ff;

  assign loading   = (state_ff == ST_COUNT) || (state_ff == ST_PROG) || (state_ff == ST_CRC);
  assign pop       = f_out_valid & loading;
  assign word_now  = {f_out_data, word_ff[31:8]};  // RL13
  assign word_done = pop && (byte_idx_ff == LAST_BYTE);
  assign crc_ok    = (word_now == CRC_SKIP) || (word_now == ~crc_run);  // RL12 RL16
  assign spi_tick  = (spi_cnt_ff == SPI_CNT_W'(SPI_HALF_CYC - 1));  // RL17

  // byte source selected by the held boot source
  always_comb begin
    f_in_valid = 1'b0;
    f_in_data  = link_byte;
    unique case (src_ff)
      SRC_SPI: begin
        f_in_valid = spi_push;
        f_in_data  = {spi_miso, spi_rx_ff[7:1]};  // RL18
      end
      SRC_OTP: begin
        f_in_valid = loading & otp_have_ff;
        f_in_data  = otp_word_ff[8*otp_idx_ff +: 8];
      end
      SRC_LINK, SRC_CHAN: f_in_valid = loading & link_valid & link_ready_ff;
      default: f_in_valid = 1'b0;
    endcase
  end

  // bytes wait here; a full fifo stalls flash clock, link ready and otp reads
  bsl_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clk       (clk),
    .reset     (reset),
    .in_valid  (f_in_valid),
    .in_data   (f_in_data),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (loading),
    .level     (f_level)
  );

  // check covers count and program bytes only
  bsl_crc32 u_crc (
    .clk   (clk),
    .reset (reset),
    .clear (state_ff == ST_DECODE),
    .en    (pop && (state_ff != ST_CRC)),  // RL15
    .data  (f_out_data),
    .crc   (crc_run)
  );

  // boot sequence
  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff      <= ST_RST_PHASE;
      phase_cnt_ff  <= '0;
      words_left_ff <= '0;
    end else begin
      unique case (state_ff)
        ST_RST_PHASE: begin
          phase_cnt_ff <= phase_cnt_ff + 1'b1;
          if (phase_cnt_ff == RST_CNT_W'(RST_PHASE_CYC - 1)) state_ff <= ST_DECODE;  // RL2
        end
        ST_DECODE: begin
          if (src_ff == SRC_JTAG)      state_ff <= ST_WAIT_JTAG;  // RL8
          else if (src_ff == SRC_RSVD) state_ff <= ST_FAIL;
          else                         state_ff <= ST_COUNT;
        end
        ST_COUNT: if (word_done) begin
          words_left_ff <= word_now;
          state_ff      <= (word_now == '0) ? ST_CRC : ST_PROG;  // RL12
        end
        ST_PROG: if (word_done) begin
          words_left_ff <= words_left_ff - 1'b1;
          if (words_left_ff == 32'h1) state_ff <= ST_CRC;
        end
        ST_CRC: if (word_done) state_ff <= crc_ok ? ST_RUN : ST_FAIL;  // RL20
        ST_WAIT_JTAG, ST_RUN, ST_FAIL: state_ff <= state_ff;
      endcase
    end
  end

  // straps sampled once at the end of the reset phase; straps must be steady by then
  always_ff @(posedge clk) begin
    if (reset) begin
      src_ff             <= SRC_JTAG;
      link_en_ff         <= '0;
      tile1_via_tile0_ff <= 1'b0;
    end else if (state_ff == ST_RST_PHASE && phase_cnt_ff == RST_CNT_W'(RST_PHASE_CYC - 1)) begin  // RL21 RL7
      tile1_via_tile0_ff <= !boot_strap[2] && boot_strap[1];  // RL9
      link_en_ff         <= '0;
      if (security_reg[SEC_BOOT_BIT])       src_ff <= SRC_OTP;   // RL11
      else if (boot_strap[1:0] == BS_JTAG)  src_ff <= SRC_JTAG;  // RL8
      else if (boot_strap[1:0] == BS_RSVD)  src_ff <= SRC_RSVD;
      else if (boot_strap == BS_LINK) begin
        src_ff     <= SRC_LINK;  // RL9
        link_en_ff <= LINKS_B;
      end else if (boot_strap == BS_CHAN) begin
        src_ff     <= SRC_CHAN;  // RL10
        link_en_ff <= LINKS_BEFH;
      end else                              src_ff <= SRC_SPI;   // RL9 RL10
    end
  end

  // pll settings: strap defaults, then software writes
  always_ff @(posedge clk) begin
    if (reset) begin
      output_divide_value_ff <= PLL_PDIV_00;
      pll_mult_ff            <= PLL_F_00;
      pll_indiv_ff           <= PLL_R_DEF;
    end else if (state_ff == ST_RST_PHASE) begin
      output_divide_value_ff <= bsl_strap_pdiv({pll_strap_hi, pll_strap_lo});  // RL3
      pll_mult_ff            <= bsl_strap_mult({pll_strap_hi, pll_strap_lo});  // RL3
      pll_indiv_ff           <= PLL_R_DEF;
    end else if (pll_cfg_we) begin
      // range limits are software's job, fields are stored as given
      output_divide_value_ff <= pll_cfg_pdiv;   // RL6 RL5
      pll_mult_ff            <= pll_cfg_mult;   // RL6
      pll_indiv_ff           <= pll_cfg_indiv;  // RL6
    end
  end

  // core clock ratio, fosc * num / den
  always_ff @(posedge clk) begin
    if (reset) begin
      core_ratio_num_ff <= '0;
      core_ratio_den_ff <= '0;
    end else begin
      core_ratio_num_ff <= {1'b0, pll_mult_ff} + 13'h0001;  // RL4
      core_ratio_den_ff <= {({4'h0, pll_indiv_ff} + 10'h001) * ({7'h00, output_divide_value_ff} + 10'h001), 1'b0};  // RL4
    end
  end

  // pad state: nothing driven in reset or during the internal phase
  always_ff @(posedge clk) begin
    if (reset) begin
      gpio_pull_en_ff <= 1'b0;  // RL1
      spi_oe_ff       <= 1'b0;  // RL1
      link_ready_ff   <= 1'b0;
    end else begin
      gpio_pull_en_ff <= (state_ff != ST_RST_PHASE);  // RL2
      spi_oe_ff       <= (state_ff != ST_RST_PHASE) && (src_ff == SRC_SPI);
      // two free slots kept since this flag lags the fill level by a cycle
      link_ready_ff   <= loading && (src_ff == SRC_LINK || src_ff == SRC_CHAN) &&
                         (f_level <= 4'(FIFO_D - 2));
    end
  end

  // flash divider, free running
  always_ff @(posedge clk) begin
    if (reset || spi_tick) spi_cnt_ff <= '0;
    else                   spi_cnt_ff <= spi_cnt_ff + 1'b1;
  end

  // flash master, mode 0: sample on rise, shift on fall
  always_ff @(posedge clk) begin
    spi_push <= 1'b0;
    if (reset || state_ff == ST_DECODE || !(loading && src_ff == SRC_SPI)) begin
      spi_sclk_ff <= 1'b0;
      spi_cs_n_ff <= 1'b1;
      spi_mosi_ff <= SPI_READ_CMD[7];
      spi_sh_ff   <= {SPI_READ_CMD, SPI_ADDR0};  // RL17
      spi_bits_ff <= '0;
      spi_hdr_ff  <= 1'b1;
      spi_rx_ff   <= '0;
      spi_push    <= 1'b0;
    end else begin
      spi_cs_n_ff <= 1'b0;
      if (spi_tick && !spi_sclk_ff) begin
        // a new byte starts only with room for it: clock held low otherwise
        if (spi_hdr_ff || spi_bits_ff != '0 || f_in_ready) begin
          spi_sclk_ff <= 1'b1;
          if (spi_hdr_ff) begin
            spi_bits_ff <= spi_bits_ff + 1'b1;
          end else if (spi_bits_ff == SPI_BYTE_END) begin
            spi_push    <= 1'b1;
            spi_bits_ff <= '0;
          end else begin
            spi_rx_ff   <= {spi_miso, spi_rx_ff[7:1]};  // RL18
            spi_bits_ff <= spi_bits_ff + 1'b1;
          end
        end
      end else if (spi_tick && spi_sclk_ff) begin
        spi_sclk_ff <= 1'b0;
        if (spi_hdr_ff) begin
          spi_sh_ff   <= {spi_sh_ff[30:0], 1'b0};
          spi_mosi_ff <= spi_sh_ff[30];
          if (spi_bits_ff == SPI_HDR_BITS) begin
            spi_hdr_ff  <= 1'b0;
            spi_bits_ff <= '0;
          end
        end
      end
    end
  end

  // otp reader: one word at a time, split low byte first
  always_ff @(posedge clk) begin
    otp_rd_ff <= 1'b0;
    if (reset || state_ff == ST_DECODE) begin
      otp_addr_ff <= OTP_BASE;  // RL19
      otp_pend_ff <= 1'b0;
      otp_have_ff <= 1'b0;
      otp_word_ff <= '0;
      otp_idx_ff  <= '0;
    end else if (loading && src_ff == SRC_OTP) begin
      if (!otp_have_ff && !otp_pend_ff) begin
        otp_rd_ff   <= 1'b1;
        otp_pend_ff <= 1'b1;
      end
      if (otp_pend_ff && otp_rvalid) begin
        otp_word_ff <= otp_rdata;
        otp_have_ff <= 1'b1;
        otp_pend_ff <= 1'b0;
      end
      if (otp_have_ff && f_in_ready) begin
        otp_idx_ff <= otp_idx_ff + 1'b1;
        if (otp_idx_ff == LAST_BYTE) begin
          otp_have_ff <= 1'b0;
          otp_addr_ff <= otp_addr_ff + 1'b1;
        end
      end
    end
  end

  // word assembly, least byte first
  always_ff @(posedge clk) begin
    if (reset || state_ff == ST_DECODE) begin
      byte_idx_ff <= '0;
      word_ff     <= '0;
    end else if (pop) begin
      byte_idx_ff <= byte_idx_ff + 1'b1;
      word_ff     <= word_now;  // RL13
    end
  end

  // ram writes from the base upward
  always_ff @(posedge clk) begin
    if (reset || state_ff == ST_DECODE) begin
      ram_we_ff    <= 1'b0;
      ram_addr_ff  <= RAM_BASE;  // RL14
      ram_wdata_ff <= '0;
    end else begin
      ram_we_ff <= word_done && (state_ff == ST_PROG);
      if (ram_we_ff) ram_addr_ff <= ram_addr_ff + 1'b1;
      if (word_done) ram_wdata_ff <= word_now;
    end
  end

  // outcome
  always_ff @(posedge clk) begin
    if (reset) begin
      exec_start_ff <= 1'b0;
      exec_addr_ff  <= RAM_BASE;
      boot_error_ff <= 1'b0;
      wait_jtag_ff  <= 1'b0;
    end else begin
      exec_start_ff <= (state_ff == ST_CRC) && word_done && crc_ok;  // RL14
      exec_addr_ff  <= RAM_BASE;                                     // RL14
      boot_error_ff <= boot_error_ff || ((state_ff == ST_CRC) && word_done && !crc_ok) ||
                       ((state_ff == ST_DECODE) && (src_ff == SRC_RSVD));  // RL20
      wait_jtag_ff  <= (state_ff == ST_WAIT_JTAG);  // RL8
    end
  end

  property p_quiet_in_phase;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_RST_PHASE) |-> (!spi_oe_ff && !gpio_pull_en_ff && !otp_rd_ff && link_en_ff == '0);
  endproperty
  a_quiet_in_phase: assert property (p_quiet_in_phase) else $error("pins active in reset phase");  // RL1
  property p_pull_timing;
    @(posedge clk) disable iff (reset)
    $rose(gpio_pull_en_ff) |-> ($past(state_ff, 2) == ST_RST_PHASE) && ($past(state_ff) == ST_DECODE);
  endproperty
  a_pull_timing: assert property (p_pull_timing) else $error("pulls enabled at wrong time");  // RL2
  property p_strap_pll;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_DECODE) |-> (pll_mult_ff == bsl_strap_mult($past({pll_strap_hi, pll_strap_lo})) &&
                                 output_divide_value_ff == bsl_strap_pdiv($past({pll_strap_hi, pll_strap_lo})) &&
                                 pll_indiv_ff == PLL_R_DEF);
  endproperty
  a_strap_pll: assert property (p_strap_pll) else $error("pll defaults not from straps");  // RL3
  property p_sw_pll;
    @(posedge clk) disable iff (reset)
    (pll_cfg_we && state_ff != ST_RST_PHASE) |=> (pll_mult_ff == $past(pll_cfg_mult) &&
                                                  pll_indiv_ff == $past(pll_cfg_indiv));
  endproperty
  a_sw_pll: assert property (p_sw_pll) else $error("pll write lost");  // RL6
  property p_secure;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_DECODE && $past(security_reg[SEC_BOOT_BIT])) |-> (src_ff == SRC_OTP);
  endproperty
  a_secure: assert property (p_secure) else $error("secure boot not from otp");  // RL11
  property p_src_held;
    @(posedge clk) disable iff (reset)
    (state_ff != ST_RST_PHASE && $past(state_ff) != ST_RST_PHASE) |-> $stable(src_ff);
  endproperty
  a_src_held: assert property (p_src_held) else $error("boot source changed");  // RL21
  property p_jtag_wait;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_DECODE && src_ff == SRC_JTAG) |=> ##1 (wait_jtag_ff && !exec_start_ff && !spi_oe_ff);
  endproperty
  a_jtag_wait: assert property (p_jtag_wait) else $error("jtag wait not entered");  // RL8
  property p_exec_addr;
    @(posedge clk) disable iff (reset)
    exec_start_ff |-> (exec_addr_ff == RAM_BASE && !boot_error_ff && $past(state_ff) == ST_CRC);
  endproperty
  a_exec_addr: assert property (p_exec_addr) else $error("run from wrong place");  // RL14
  property p_crc_fail;
    @(posedge clk) disable iff (reset)
    (state_ff == ST_CRC && word_done && word_now != CRC_SKIP && word_now != ~crc_run)
      |=> (boot_error_ff && !exec_start_ff) [*2];
  endproperty
  a_crc_fail: assert property (p_crc_fail) else $error("bad crc not flagged");  // RL20
  property p_spi_half;
    @(posedge clk) disable iff (reset)
    $rose(spi_sclk_ff) |-> $past(spi_cnt_ff) == SPI_CNT_W'(SPI_HALF_CYC - 1);
  endproperty
  a_spi_half: assert property (p_spi_half) else $error("flash clock off divider");  // RL17
endmodule : bsl_loader
`default_nettype wire

// file: dv/bsl_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
// serial flash, mode 0
module bsl_flash_model (
  // flash pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  output var logic  miso
);
  logic [7:0]  mem [0:31]; // image from address zero
  logic [31:0] hdr;        // command and address seen
  int          n;          // rising edges this frame
  initial miso = 1'b0;
  // count restarts at each select
  always @(negedge cs_n) n = 0;
  // header arrives msb first
  always @(posedge sclk) if (!cs_n) begin
    if (n < 32) hdr = {hdr[30:0], mosi};
    n++;
  end
  // bit on falling edge; no pull, so idle shows inverse
  always @(negedge sclk or posedge cs_n)
    miso = (!cs_n && n >= 32) ? mem[(n-32)/8][(n-32)%8] : ~miso;
endmodule : bsl_flash_model
`default_nettype wire

// file: dv/tb_boot_strap_and_image_loader.sv
`timescale 1ns/1ps
`default_nettype none
module tb_boot_strap_and_image_loader;
  // inputs of the loader
  logic        clk, reset, pll_strap_lo, pll_strap_hi, pll_cfg_we, link_valid, otp_rvalid;
  logic [2:0]  boot_strap, pll_cfg_pdiv;
  logic [5:0]  pll_cfg_indiv;
  logic [7:0]  link_byte;
  logic [11:0] pll_cfg_mult;
  logic [31:0] security_reg, otp_rdata;
  wire logic   link_ready_ff, spi_miso;
  logic [7:0]  img[$]; // image bytes in wire order
  logic [31:0] wq[$];  // words due in ram
  int          num_errors, n_tests, ex, wi, oi, cyc;
  bsl_loader uut (.clk, .reset, .pll_strap_lo, .pll_strap_hi, .boot_strap, .security_reg, .pll_cfg_we,
    .pll_cfg_pdiv, .pll_cfg_mult, .pll_cfg_indiv, .output_divide_value_ff(), .pll_mult_ff(), .pll_indiv_ff(),
    .core_ratio_num_ff(), .core_ratio_den_ff(), .gpio_pull_en_ff(), .spi_oe_ff(), .link_en_ff(),
    .spi_sclk_ff(), .spi_cs_n_ff(), .spi_mosi_ff(), .spi_miso, .link_valid, .link_byte, .link_ready_ff,
    .otp_rd_ff(), .otp_addr_ff(), .otp_rvalid, .otp_rdata, .ram_we_ff(), .ram_addr_ff(), .ram_wdata_ff(),
    .wait_jtag_ff(), .tile1_via_tile0_ff(), .exec_start_ff(), .exec_addr_ff(), .boot_error_ff());
  bsl_flash_model fm (.sclk(uut.spi_sclk_ff), .cs_n(uut.spi_cs_n_ff), .mosi(uut.spi_mosi_ff), .miso(spi_miso));
  always #2 clk = ~clk;
  // reflected remainder, not inverted
  function automatic logic [31:0] crc(input logic [7:0] q[$]);
    logic [31:0] r = 32'hFFFFFFFF;
    foreach (q[i]) for (int b = 0; b < 8; b++) r = (r >> 1) ^ ((r[0] ^ q[i][b]) ? 32'hEDB88320 : 32'h0);
    return r;
  endfunction : crc
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task end_sim;
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  // reset, random low straps, wait out reset phase
  task boot(input logic [2:0] bs, input logic [31:0] sr, input int s, input int m);
    logic [1:0]  st;
    logic [31:0] w;
    st = $urandom;
    img = {};
    wq = {};
    // m: 1 skips the check, 2 spoils it
    for (int i = 0; i < s + 2; i++) begin
      w = i == 0 ? s : i <= s ? $urandom : m == 1 ? 32'h0D15AB1E : ~crc(img) ^ 32'(m == 2);
      if (i > 0 && i <= s) wq.push_back(w);
      for (int b = 0; b < 4; b++) img.push_back(w[8*b+:8]);
    end
    foreach (img[i]) fm.mem[i] = img[i];
    {pll_strap_hi, pll_strap_lo, boot_strap, security_reg} <= {st, bs, sr};
    reset <= 1'b1;
    {ex, wi, oi} = 0;
    repeat (10) @(posedge clk);
    chk("pins", {uut.gpio_pull_en_ff, uut.spi_oe_ff, uut.link_en_ff, uut.spi_cs_n_ff}, 8'h01);
    reset <= 1'b0;
    repeat (3700) @(posedge clk);
    chk("pll", {uut.output_divide_value_ff, uut.pll_mult_ff, uut.pll_indiv_ff},
      {st ? 3'h2 : 3'h1, st == 0 ? 12'h07A : st == 3 ? 12'h077 : st == 2 ? 12'h031 : 12'h017, 6'h0});
    chk("pull", uut.gpio_pull_en_ff, 1'b0);
    repeat (60) @(posedge clk);
    chk("pull", uut.gpio_pull_en_ff, 1'b1);
  endtask : boot
  // each byte held until taken
  task snd;
    foreach (img[i]) begin
      {link_valid, link_byte} <= {1'b1, img[i]};
      do @(posedge clk); while (link_ready_ff !== 1'b1);
    end
    link_valid <= 1'b0;
  endtask : snd
  // bounded wait for start or error
  task done(input logic [31:0] e, input logic er);
    for (int k = 0; k < 30000 && ex == 0 && uut.boot_error_ff !== 1'b1; k++) @(posedge clk);
    repeat (4) @(posedge clk);
    chk("exec", ex, e);
    chk("error", uut.boot_error_ff, er);
  endtask : done
  // ram and start monitor, otp answers next cycle, hang guard
  always @(posedge clk) begin
    if (uut.ram_we_ff === 1'b1) begin
      chk("ram_addr", uut.ram_addr_ff, wi);
      chk("ram_data", uut.ram_wdata_ff, wq[wi]);
      wi++;
    end
    if (uut.exec_start_ff === 1'b1) begin
      ex++;
      chk("exec_addr", uut.exec_addr_ff, 0);
    end
    otp_rvalid <= 1'b0;
    if (uut.otp_rd_ff === 1'b1) begin
      chk("otp_addr", uut.otp_addr_ff, oi);
      {otp_rvalid, otp_rdata} <= {1'b1, img[4*oi+3], img[4*oi+2], img[4*oi+1], img[4*oi]};
      oi++;
    end
    if (++cyc == 80000) begin
      num_errors++;
      end_sim;
    end
  end
  initial begin
    {clk, pll_strap_lo, pll_strap_hi, pll_cfg_we, link_valid, otp_rvalid, boot_strap, pll_cfg_pdiv} = 0;
    {pll_cfg_indiv, link_byte, pll_cfg_mult, security_reg, otp_rdata} = 0;
    reset = 1'b1;
    void'($urandom(69975));
    @(posedge clk);
    boot(3'h2, 0, 3, 0);
    chk("src", {uut.link_en_ff, uut.tile1_via_tile0_ff}, 6'h03);
    snd;
    done(1, 0);
    boot(3'h6, 0, 0, 1);
    chk("src", {uut.link_en_ff, uut.tile1_via_tile0_ff}, 6'h3E);
    snd;
    done(1, 0);
    boot(3'h2, 0, 2, 2);
    snd;
    done(0, 1);
    boot({1'($urandom), 2'h0}, 0, 0, 0);
    chk("jtag", {uut.wait_jtag_ff, uut.boot_error_ff}, 2'h2);
    boot({1'($urandom), 2'h1}, 0, 0, 0);
    chk("rsvd", {uut.wait_jtag_ff, uut.boot_error_ff}, 2'h1);
    boot(3'h1, $urandom | 32'h20, 2, 0);
    done(1, 0);
    boot(3'h7, 0, 1, 0);
    chk("src", {uut.spi_oe_ff, uut.tile1_via_tile0_ff}, 2'h2);
    done(1, 0);
    chk("cmd", fm.hdr, 32'h03000000);
    {pll_cfg_we, pll_cfg_pdiv, pll_cfg_mult, pll_cfg_indiv} <= {1'b1, 21'($urandom)};
    @(posedge clk);
    pll_cfg_we <= 1'b0;
    repeat (3) @(posedge clk);
    chk("cfg", {uut.output_divide_value_ff, uut.pll_mult_ff, uut.pll_indiv_ff},
      {pll_cfg_pdiv, pll_cfg_mult, pll_cfg_indiv});
    chk("num", uut.core_ratio_num_ff, pll_cfg_mult + 13'h1);
    chk("den", uut.core_ratio_den_ff, 2 * (pll_cfg_indiv + 1) * (pll_cfg_pdiv + 1));
    end_sim;
  end
endmodule : tb_boot_strap_and_image_loader
`default_nettype wire
